// *** common/cct_pkg.sv ***
// Constants, field layout and types of the cascade trigger timing block.
// Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
package cct_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned PS_PER_US = 1000000;
  localparam int unsigned CYC_PER_US = PS_PER_US / CLK_PERIOD_PS;
  localparam int unsigned US_PER_MS = 1000;
  localparam int unsigned TRIG_PULSE_US = 10;

  // ==========================================================
  // Register map, primary view
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] REG_CAS_LO = 12'h000;
  localparam logic [11:0] REG_CAS_HI = 12'h004;
  localparam logic [11:0] REG_PIN = 12'h008;
  localparam logic [11:0] REG_STAT = 12'h00c;

  // ==========================================================
  // Register map, subindex view: page, subindex, word
  localparam logic [3:0] ALT_CAS_PAGE = 4'h1;
  localparam logic [3:0] ALT_PIN_PAGE = 4'h2;
  localparam logic [5:0] SUB_CAS_EN = 6'h01;
  localparam logic [5:0] SUB_CAS_ROLE = 6'h02;
  localparam logic [5:0] SUB_CAS_DLY = 6'h03;
  localparam logic [5:0] SUB_CAS_CYC = 6'h05;
  localparam logic [5:0] SUB_PIN_OUTF = 6'h01;
  localparam logic [5:0] SUB_PIN_INF = 6'h02;
  localparam logic [5:0] SUB_PIN_POL = 6'h03;
  localparam logic [5:0] SUB_PIN_DIR = 6'h04;
  localparam logic [11:0] ALT_CAS_EN = {ALT_CAS_PAGE, SUB_CAS_EN, 2'b00};
  localparam logic [11:0] ALT_CAS_ROLE = {ALT_CAS_PAGE, SUB_CAS_ROLE, 2'b00};
  localparam logic [11:0] ALT_CAS_DLY = {ALT_CAS_PAGE, SUB_CAS_DLY, 2'b00};
  localparam logic [11:0] ALT_CAS_CYC = {ALT_CAS_PAGE, SUB_CAS_CYC, 2'b00};
  localparam logic [11:0] ALT_PIN_OUTF = {ALT_PIN_PAGE, SUB_PIN_OUTF, 2'b00};
  localparam logic [11:0] ALT_PIN_INF = {ALT_PIN_PAGE, SUB_PIN_INF, 2'b00};
  localparam logic [11:0] ALT_PIN_POL = {ALT_PIN_PAGE, SUB_PIN_POL, 2'b00};
  localparam logic [11:0] ALT_PIN_DIR = {ALT_PIN_PAGE, SUB_PIN_DIR, 2'b00};

  // ==========================================================
  // Field positions and widths
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned DLY_W = 32;
  localparam int unsigned CYC_W = 16;
  localparam int unsigned CAS_DLY_POS = 0;
  localparam int unsigned CAS_CYC_POS = 32;
  localparam int unsigned CAS_ROLE_POS = 48;
  localparam int unsigned CAS_EN_POS = 56;
  localparam int unsigned PIN_OUTF_POS = 0;
  localparam int unsigned PIN_INF_POS = 8;
  localparam int unsigned PIN_POL_POS = 16;
  localparam int unsigned PIN_DIR_POS = 24;
  localparam int unsigned STAT_MST_BIT = 0;
  localparam int unsigned STAT_LSN_BIT = 1;
  localparam int unsigned STAT_DLY_BIT = 2;
  localparam int unsigned STAT_LVL_BIT = 3;
  localparam int unsigned STAT_CNT_POS = 16;

  // ==========================================================
  // Field values and reset values
  localparam logic [7:0] EN_ACTIVE = 8'h01;
  localparam logic [7:0] ROLE_MASTER = 8'h01;
  localparam logic [7:0] ROLE_SLAVE = 8'h00;
  localparam logic [7:0] DIR_OUT = 8'h00;
  localparam logic [7:0] DIR_IN = 8'h01;
  localparam logic [7:0] POL_LIGHT = 8'h00;
  localparam logic [7:0] OUTF_TRIG = 8'h03;
  localparam logic [7:0] INF_TRIG = 8'h01;
  localparam logic [63:0] RST_CAS = 64'h0000_0000_0000_0000;
  localparam logic [31:0] RST_PIN = 32'h0100_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_OFF, ST_MASTER, ST_LISTEN, ST_DELAY} cct_state_t;

endpackage

// *** core/cct_core.sv ***
// Cascade trigger timing: master trigger generator and slave delayed scan start.
// Assumes an AXI4-Lite master on clk_sys and an asynchronous shared trigger pin.
//
// Function
// - Cascade runs only while the enable field, bit 56, holds 1.
// - Role field, bit 48: 1 makes master emitting trigger, 0 slave waiting.
// - Cycle field, bit 32, in ms: master fires one trigger per period.
// - Slave starts scan after delay field, bit 0, in us, from trigger.
// - Pin direction field, bit 24: 0 drives trigger pin, 1 takes it in.
// - Pin polarity field, bit 16, is 0 for non-inverted trigger levels.
// - Master pin output function, bit 0, is 3 to send the trigger.
// - Slave pin input function, bit 8, is 1 to take the trigger.
// - Subindex view of cascade fields: 01 enable, 02 role, 05 period, 03 delay.
// - Subindex view of pin fields: 04 direction, 03 polarity, 01 out, 02 in.
`timescale 1ns/1ps

module cct_core (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [cct_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cct_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trig_pin_i,
  output logic trig_pin_o,
  output logic trig_pin_oe_b,
  output logic scan_start
);
  import cct_pkg::*;

  // ==========================================================
  // Declarations
  logic [63:0] cas_r, cas_nxt;
  logic [31:0] pin_r, pin_nxt;
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic [11:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt, rd_word;
  logic rd_err, wr_err, wr_go;
  logic [2:0] sync_r, sync_nxt;
  logic filt_r, filt_nxt, act_d_r, act_d_nxt;
  cct_state_t state_r, state_nxt;
  logic [CYC_W-1:0] per_r, per_nxt;
  logic [DLY_W-1:0] dly_r, dly_nxt;
  logic [3:0] pul_r, pul_nxt;
  logic trig_r, trig_nxt, scan_r, scan_nxt, pin_lvl_r, pin_lvl_nxt;
  logic [15:0] scan_cnt_r, scan_cnt_nxt;
  logic div_clr, fire, us_tick, ms_tick, act_lvl, in_edge, master_ok, slave_ok;
  logic [7:0] f_en, f_role, f_outf, f_inf, f_pol, f_dir;
  logic [CYC_W-1:0] f_cyc;
  logic [DLY_W-1:0] f_dly;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Field views
  assign f_en = cas_r[CAS_EN_POS +: BYTE_W];
  assign f_role = cas_r[CAS_ROLE_POS +: BYTE_W];
  assign f_cyc = cas_r[CAS_CYC_POS +: CYC_W];
  assign f_dly = cas_r[CAS_DLY_POS +: DLY_W];
  assign f_outf = pin_r[PIN_OUTF_POS +: BYTE_W];
  assign f_inf = pin_r[PIN_INF_POS +: BYTE_W];
  assign f_pol = pin_r[PIN_POL_POS +: BYTE_W];
  assign f_dir = pin_r[PIN_DIR_POS +: BYTE_W];

  // Master needs enable, master role, output pin routed to trigger
  assign master_ok = (f_en == EN_ACTIVE) && (f_role == ROLE_MASTER)
    && (f_dir == DIR_OUT) && (f_outf == OUTF_TRIG);
  // Slave needs enable, slave role, input pin taken as trigger
  assign slave_ok = (f_en == EN_ACTIVE) && (f_role == ROLE_SLAVE)
    && (f_dir == DIR_IN) && (f_inf == INF_TRIG);

  // ==========================================================
  // AXI4-Lite slave
  assign s_axi_awready = ce && !aw_full_r;
  assign s_axi_wready = ce && !w_full_r;
  assign s_axi_arready = ce && !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign wr_go = ce && aw_full_r && w_full_r && !bvalid_r;

  always_comb begin
    rd_err = 1'b0;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      REG_CAS_LO: rd_word = cas_r[31:0];
      REG_CAS_HI: rd_word = cas_r[63:32];
      REG_PIN: rd_word = pin_r;
      REG_STAT: begin
        rd_word[STAT_MST_BIT] = (state_r == ST_MASTER);
        rd_word[STAT_LSN_BIT] = (state_r == ST_LISTEN);
        rd_word[STAT_DLY_BIT] = (state_r == ST_DELAY);
        rd_word[STAT_LVL_BIT] = filt_r;
        rd_word[STAT_CNT_POS +: 16] = scan_cnt_r;
      end
      ALT_CAS_EN: rd_word = 32'(f_en);
      ALT_CAS_ROLE: rd_word = 32'(f_role);
      ALT_CAS_DLY: rd_word = f_dly;
      ALT_CAS_CYC: rd_word = 32'(f_cyc);
      ALT_PIN_OUTF: rd_word = 32'(f_outf);
      ALT_PIN_INF: rd_word = 32'(f_inf);
      ALT_PIN_POL: rd_word = 32'(f_pol);
      ALT_PIN_DIR: rd_word = 32'(f_dir);
      default: rd_err = 1'b1;
    endcase
  end

  always_comb begin
    cas_nxt = cas_r;
    pin_nxt = pin_r;
    wr_err = 1'b0;
    case (aw_addr_r)
      REG_CAS_LO: cas_nxt[31:0] = merge(cas_r[31:0], wdata_r, wstrb_r);
      REG_CAS_HI: cas_nxt[63:32] = merge(cas_r[63:32], wdata_r, wstrb_r);
      REG_PIN: pin_nxt = merge(pin_r, wdata_r, wstrb_r);
      ALT_CAS_EN: cas_nxt[CAS_EN_POS +: BYTE_W] = 8'(merge(32'(f_en), wdata_r, wstrb_r));
      ALT_CAS_ROLE: cas_nxt[CAS_ROLE_POS +: BYTE_W] =
        8'(merge(32'(f_role), wdata_r, wstrb_r));
      ALT_CAS_DLY: cas_nxt[CAS_DLY_POS +: DLY_W] = merge(f_dly, wdata_r, wstrb_r);
      ALT_CAS_CYC: cas_nxt[CAS_CYC_POS +: CYC_W] =
        16'(merge(32'(f_cyc), wdata_r, wstrb_r));
      ALT_PIN_OUTF: pin_nxt[PIN_OUTF_POS +: BYTE_W] =
        8'(merge(32'(f_outf), wdata_r, wstrb_r));
      ALT_PIN_INF: pin_nxt[PIN_INF_POS +: BYTE_W] =
        8'(merge(32'(f_inf), wdata_r, wstrb_r));
      ALT_PIN_POL: pin_nxt[PIN_POL_POS +: BYTE_W] =
        8'(merge(32'(f_pol), wdata_r, wstrb_r));
      ALT_PIN_DIR: pin_nxt[PIN_DIR_POS +: BYTE_W] =
        8'(merge(32'(f_dir), wdata_r, wstrb_r));
      default: wr_err = 1'b1;
    endcase
    if (!wr_go) begin
      cas_nxt = cas_r;
      pin_nxt = pin_r;
    end
  end

  always_comb begin
    aw_full_nxt = aw_full_r;
    aw_addr_nxt = aw_addr_r;
    w_full_nxt = w_full_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = {s_axi_awaddr[11:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (wr_go) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = rd_err ? RESP_SLVERR : RESP_OKAY;
      rdata_nxt = rd_word;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cas_r <= RST_CAS;
      pin_r <= RST_PIN;
      aw_full_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_full_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (ce) begin
      cas_r <= cas_nxt;
      pin_r <= pin_nxt;
      aw_full_r <= aw_full_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_full_r <= w_full_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Microsecond and millisecond ticks
  cct_tick_div #(.DIV(CYC_PER_US)) u_us_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .clr(div_clr),
    .step(1'b1),
    .tick(us_tick)
  );

  cct_tick_div #(.DIV(US_PER_MS)) u_ms_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .clr(div_clr),
    .step(us_tick),
    .tick(ms_tick)
  );

  // ==========================================================
  // Trigger pin input filter and edge
  assign act_lvl = filt_r ^ (f_pol != POL_LIGHT);
  assign in_edge = act_lvl && !act_d_r;

  always_comb begin
    sync_nxt = {sync_r[1:0], trig_pin_i};
    filt_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : filt_r;
    act_d_nxt = act_lvl;
  end

  // ==========================================================
  // Trigger and scan sequencer
  always_comb begin
    state_nxt = state_r;
    per_nxt = per_r;
    dly_nxt = dly_r;
    pul_nxt = pul_r;
    trig_nxt = trig_r;
    scan_nxt = 1'b0;
    div_clr = 1'b0;
    fire = 1'b0;
    case (state_r)
      ST_OFF: begin
        if (master_ok) begin
          state_nxt = ST_MASTER;
          fire = 1'b1;
        end else if (slave_ok) begin
          state_nxt = ST_LISTEN;
        end
      end
      ST_MASTER: begin
        if (!master_ok) begin
          state_nxt = ST_OFF;
          trig_nxt = 1'b0;
          pul_nxt = 4'h0;
        end else begin
          if (us_tick && pul_r != 4'h0) begin
            pul_nxt = pul_r - 4'h1;
            trig_nxt = (pul_r != 4'h1);
          end
          if (ms_tick) begin
            if (f_cyc != '0 && (per_r + 16'h0001) >= f_cyc) begin
              fire = 1'b1;
            end else begin
              per_nxt = per_r + 16'h0001;
            end
          end
        end
      end
      ST_LISTEN: begin
        if (!slave_ok) begin
          state_nxt = ST_OFF;
        end else if (in_edge) begin
          state_nxt = ST_DELAY;
          dly_nxt = f_dly;
          div_clr = 1'b1;
        end
      end
      ST_DELAY: begin
        if (!slave_ok) begin
          state_nxt = ST_OFF;
        end else if (dly_r == '0) begin
          scan_nxt = 1'b1;
          state_nxt = ST_LISTEN;
        end else if (us_tick) begin
          dly_nxt = dly_r - 32'h1;
        end
      end
      default: state_nxt = ST_OFF;
    endcase
    if (fire) begin
      per_nxt = '0;
      pul_nxt = 4'(TRIG_PULSE_US);
      trig_nxt = 1'b1;
      scan_nxt = 1'b1;
      div_clr = 1'b1;
    end
    scan_cnt_nxt = scan_nxt ? scan_cnt_r + 16'h0001 : scan_cnt_r;
    pin_lvl_nxt = trig_nxt ^ (f_pol != POL_LIGHT);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync_r <= 3'h0;
      filt_r <= 1'b0;
      act_d_r <= 1'b1;
      state_r <= ST_OFF;
      per_r <= '0;
      dly_r <= '0;
      pul_r <= 4'h0;
      trig_r <= 1'b0;
      scan_r <= 1'b0;
      scan_cnt_r <= 16'h0000;
      pin_lvl_r <= 1'b0;
    end else if (ce) begin
      sync_r <= sync_nxt;
      filt_r <= filt_nxt;
      act_d_r <= act_d_nxt;
      state_r <= state_nxt;
      per_r <= per_nxt;
      dly_r <= dly_nxt;
      pul_r <= pul_nxt;
      trig_r <= trig_nxt;
      scan_r <= scan_nxt;
      scan_cnt_r <= scan_cnt_nxt;
      pin_lvl_r <= pin_lvl_nxt;
    end
  end

  assign scan_start = scan_r;
  assign trig_pin_o = pin_lvl_r;
  assign trig_pin_oe_b = (f_dir != DIR_OUT);

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_off_when_disabled: assert property (
    (ce && f_en != EN_ACTIVE) |=> (state_r == ST_OFF)) else $error("active while disabled");
  chk_trig_only_master: assert property (
    trig_r |-> (state_r == ST_MASTER)) else $error("trigger outside master role");
  chk_period_restart: assert property (
    (ce && state_r == ST_MASTER && master_ok && ms_tick && f_cyc == 16'h0001)
    |=> (trig_r && scan_r && per_r == '0)) else $error("period trigger missed");
  chk_delay_hold: assert property (
    (ce && state_r == ST_DELAY && dly_r != '0) |=> !scan_r) else $error("scan before delay");
  chk_master_drives: assert property (
    (state_r == ST_MASTER && master_ok) |-> !trig_pin_oe_b) else $error("master not driving pin");
  chk_pin_level: assert property (
    (ce && $changed(trig_r) && $stable(f_pol) && f_pol == POL_LIGHT) |-> (trig_pin_o == trig_r))
    else $error("pin level wrong");
  chk_out_func: assert property (
    (ce && f_outf != OUTF_TRIG && state_r == ST_OFF) |=> !trig_r) else $error("trigger unrouted");
  chk_edge_to_delay: assert property (
    (ce && state_r == ST_LISTEN && slave_ok && in_edge)
    |=> (state_r == ST_DELAY && dly_r == $past(f_dly))) else $error("edge not taken");
  chk_alt_en_write: assert property (
    (wr_go && aw_addr_r == ALT_CAS_EN && wstrb_r[0]) |=> (f_en == $past(wdata_r[7:0])))
    else $error("subindex enable write lost");
  chk_alt_dir_write: assert property (
    (wr_go && aw_addr_r == ALT_PIN_DIR && wstrb_r[0]) |=> (f_dir == $past(wdata_r[7:0])))
    else $error("subindex direction write lost");
  chk_ignore_edges: assert property (
    (ce && state_r == ST_DELAY && slave_ok && dly_r > 32'h1) |=> (state_r == ST_DELAY))
    else $error("delay left early");

  cov_master_fire: cover property (state_r == ST_MASTER && fire);
  cov_slave_scan: cover property (state_r == ST_DELAY && scan_nxt && ce);
  cov_alt_write: cover property (wr_go && aw_addr_r == ALT_CAS_DLY);

endmodule // cct_core

// *** core/cct_tick_div.sv ***
// Step divider giving one tick per DIV steps, clearable.
// Assumes clk_sys, rst_b and ce of the enclosing block.
`timescale 1ns/1ps

module cct_tick_div #(
  parameter int unsigned DIV = 2
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic clr,
  input wire logic step,
  output logic tick
);

  // ==========================================================
  // Counter
  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  assign tick = ce && step && !clr && (cnt_r == LAST);

  always_comb begin
    cnt_nxt = cnt_r;
    if (clr) begin
      cnt_nxt = '0;
    end else if (step) begin
      cnt_nxt = (cnt_r == LAST) ? '0 : CW'(cnt_r + 1'b1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule // cct_tick_div

// *** verif/cascade_trigger_timing_bench.sv ***
// Bench of the cascade trigger block: register bus tasks and trigger checks.
// Assumes cct_core, cct_peer and cct_pkg are compiled first.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, (exp), (got)); end end

module cascade_trigger_timing_bench;
  import cct_pkg::*;
  localparam int LIMIT = 60000;
  logic clk_sys, rst_b, ce, go, line, peer_o, tp_q;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic trig_pin_o, trig_pin_oe_b, scan_start;
  logic [15:0] n_seen;
  int n_fail = 0, compares = 0, cyc = 0, n_scan = 0, t_scan = 0, t_rise = 0, t_fall = 0;
  int ns, tg, diff;

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Shared line: whoever is the output side drives it
  assign line = trig_pin_oe_b ? peer_o : trig_pin_o;

  cct_core i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .trig_pin_i(line),
    .trig_pin_o(trig_pin_o), .trig_pin_oe_b(trig_pin_oe_b), .scan_start(scan_start));

  cct_peer i_peer (.clk_sys(clk_sys), .rst_b(rst_b), .go(go), .line(line),
    .peer_o(peer_o), .n_seen(n_seen));

  // ==========================================================
  // Monitor and timeout
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    tp_q <= trig_pin_o;
    if (scan_start === 1'b1) begin
      n_scan <= n_scan + 1;
      t_scan <= cyc;
    end
    if (trig_pin_o === 1'b1 && tp_q === 1'b0) t_rise <= cyc;
    if (trig_pin_o === 1'b0 && tp_q === 1'b1) t_fall <= cyc;
    if (cyc == LIMIT) begin
      n_fail++;
      summarize();
    end
  end

  // ==========================================================
  // Tasks
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic pulse();
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
  endtask

  task automatic summarize();
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    go = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    waitc(10);
    rst_b <= 1'b1;
    rd(REG_CAS_LO);
    `CHK("cas_lo", RST_CAS[31:0], rd_d)
    rd(REG_CAS_HI);
    `CHK("cas_hi", RST_CAS[63:32], rd_d)
    rd(REG_PIN);
    `CHK("pin", RST_PIN, rd_d)
    `CHK("oe_b", 1'b1, trig_pin_oe_b)
    rd(12'hffc);
    `CHK("bad_rresp", RESP_SLVERR, resp)
    `CHK("bad_rdata", 32'h0000_0000, rd_d)
    wr(12'hffc, 32'hffff_ffff);
    `CHK("bad_bresp", RESP_SLVERR, resp)
    // Master set up with cascade still off; period covers all units
    wr(ALT_CAS_CYC, 32'h0000_0001);
    wr(ALT_CAS_ROLE, {24'h0, ROLE_MASTER});
    wr(ALT_PIN_DIR, {24'h0, DIR_OUT});
    wr(ALT_PIN_POL, {24'h0, POL_LIGHT});
    wr(ALT_PIN_OUTF, {24'h0, OUTF_TRIG});
    waitc(50);
    `CHK("off_trig", 1'b0, trig_pin_o)
    `CHK("off_scan", 0, n_scan)
    `CHK("out_oe_b", 1'b0, trig_pin_oe_b)
    // Clock enable low stalls the register bus
    ce <= 1'b0;
    waitc(3);
    `CHK("ce_aw", 1'b0, s_axi_awready)
    `CHK("ce_ar", 1'b0, s_axi_arready)
    ce <= 1'b1;
    rd(REG_CAS_HI);
    `CHK("alt_cas", {8'h00, ROLE_MASTER, 16'h0001}, rd_d)
    rd(REG_PIN);
    `CHK("alt_pin", {DIR_OUT, POL_LIGHT, 8'h00, OUTF_TRIG}, rd_d)
    wr(ALT_CAS_EN, {24'h0, EN_ACTIVE});
    waitc(4);
    `CHK("mst_trig", 1'b1, trig_pin_o)
    `CHK("mst_scan", 1, n_scan)
    waitc(2600);
    `CHK("pulse_w", TRIG_PULSE_US * CYC_PER_US, t_fall - t_rise)
    waitc(20000);
    `CHK("one_trig", 16'h0001, n_seen)
    // Slave: delay of each slave is the sum of preceding unit scan times
    wr(REG_PIN, {DIR_IN, POL_LIGHT, INF_TRIG, 8'h00});
    wr(REG_CAS_HI, {EN_ACTIVE, ROLE_SLAVE, 16'h0001});
    waitc(5);
    `CHK("in_oe_b", 1'b1, trig_pin_oe_b)
    rd(REG_STAT);
    `CHK("stat", (32'h1 << STAT_CNT_POS) | (32'h1 << STAT_LSN_BIT), rd_d)
    for (int d = 0; d < 3; d++) begin
      wr(REG_CAS_LO, 32'(d));
      rd(ALT_CAS_DLY);
      `CHK("alt_dly", 32'(d), rd_d)
      ns = n_scan;
      waitc(10);
      tg = cyc;
      pulse();
      if (d != 0) begin
        waitc(40);
        pulse();
      end
      waitc(700);
      diff = t_scan - tg - int'(CYC_PER_US) * d;
      `CHK("dly_time", 1'b1, diff >= 5 && diff <= 9)
      `CHK("one_scan", 1, n_scan - ns)
    end
    summarize();
  end
endmodule // cascade_trigger_timing_bench

// *** verif/cct_peer.sv ***
// Far-side cascade unit: pulse source on the shared line and line watcher.
// Assumes the bench resolves the shared line from both drivers.
`timescale 1ns/1ps

module cct_peer #(
  parameter int unsigned WIDTH = 20
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic go,
  input wire logic line,
  output logic peer_o,
  output logic [15:0] n_seen
);
  logic [15:0] cnt_r;
  logic line_r;

  // ==========================================================
  // Trigger pulse and rising edge count
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 16'h0000;
      line_r <= 1'b0;
      n_seen <= 16'h0000;
    end else begin
      if (go) begin
        cnt_r <= 16'(WIDTH);
      end else if (cnt_r != 16'h0000) begin
        cnt_r <= cnt_r - 16'h0001;
      end
      line_r <= line;
      if (line && !line_r) begin
        n_seen <= n_seen + 16'h0001;
      end
    end
  end

  // Drives light-switching level while pulsing
  assign peer_o = (cnt_r != 16'h0000);
endmodule // cct_peer
